// file: verilog/tpt_pkg.sv
package tpt_pkg;

    ////////////////////////////////////////////////////////////////////////
    // counter geometry
    localparam int unsigned CNT_W = 16;
    localparam logic [15:0] CNT_IDLE = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CMP_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // mode_select_field codes handled here
    localparam logic [2:0] MODE_TRIG_PWM = 3'h2;
    localparam logic [2:0] MODE_ONE_SHOT = 3'h3;

    // trigger edge selection
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic {
        TPT_IDLE,
        TPT_RUN
    } tpt_state_e;

    typedef struct packed {
        logic counter_enable_bit;
        logic [2:0] mode_select_field;
        logic [1:0] trigger_edge_ctrl_reg;
    } tpt_ctrl_s;

    typedef struct packed {
        logic period_wr;
        logic width_wr;
        logic [15:0] data;
    } tpt_wr_s;

    typedef struct packed {
        logic [15:0] count_readback_reg;
        logic [15:0] period_compare_reg;
        logic [15:0] width_compare_reg;
    } tpt_status_s;

endpackage : tpt_pkg

// file: verilog/tpt_triggered_pulse_timer.sv
`timescale 1ns/1ps
// Function
// - Triggered PWM mode 010: each trigger clears counter to zero and (re)starts it.
// - PWM period interrupt fires the count after period match, as counter clears.
// - PWM period is period value plus one clocks; active width equals width value.
// - Compare values reach shadows at the starting trigger, else only after a width write, at the next clear.
// - Width zero gives 0% output; width interrupt still recurs with period FFFFH.
// - Width equal to period plus one gives 100%; impossible with period FFFFH.
// - Trigger just after width match clears counter, asserts output, keeps counting.
// - Trigger just before width match suppresses width interrupt, output stays high.
// - Trigger just after period match clears counter, extending the active period.
// - Trigger just before period match suppresses period interrupt, asserts output.
// - PWM width interrupt fires in the clock the counter equals the width value.
// - Mode 011 selects one-shot: enable makes the timer wait for a trigger.
// - One-shot trigger clears FFFFH to 0000H; after pulse counter returns FFFFH, stops.
// - One-shot triggers arriving while a pulse is in progress are ignored.
// - One-shot delay equals width value; active width is period minus width plus one.
// - In one-shot the aux output is active while counting, inactive while waiting.
// - Trigger is the selected input edge or software setting the trigger bit.
// - One-shot period interrupt fires the count after match; width on match itself.
// - One-shot width match raises output; period match drops output and stops.
// - One-shot compare writes act at once; passed values wrap through FFFFH first.
module tpt_triggered_pulse_timer (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire tpt_pkg::tpt_ctrl_s ctrl,
    input wire logic soft_trigger_bit,
    input wire logic trigger_in,
    input wire tpt_pkg::tpt_wr_s wr,
    output logic period_match_irq,
    output logic width_match_irq,
    output logic pulse_out,
    output logic aux_toggle_out,
    output tpt_pkg::tpt_status_s status
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    tpt_pkg::tpt_state_e state_q;
    tpt_pkg::tpt_state_e state_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] per_reg_q;
    logic [15:0] wid_reg_q;
    logic [15:0] per_sh_q;
    logic [15:0] wid_sh_q;
    logic [15:0] per_cmp;
    logic [15:0] wid_cmp;
    logic [15:0] wid_next;
    logic pend_q;
    logic trig_prev_q;
    logic pulse_q;
    logic pulse_d;
    logic aux_q;
    logic aux_d;
    logic per_irq_q;
    logic mode_pwm;
    logic mode_os;
    logic active;
    logic running;
    logic ext_edge;
    logic trig;
    logic per_hit;
    logic wid_hit;
    logic restart;
    logic load;

    ////////////////////////////////////////////////////////////////////////
    // mode decode and trigger detection
    assign mode_pwm = ctrl.counter_enable_bit
        && (ctrl.mode_select_field == tpt_pkg::MODE_TRIG_PWM);
    assign mode_os = ctrl.counter_enable_bit
        && (ctrl.mode_select_field == tpt_pkg::MODE_ONE_SHOT);
    assign active = mode_pwm || mode_os;
    assign running = (state_q == tpt_pkg::TPT_RUN);

    // previous trigger level for edge detection
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            trig_prev_q <= 1'b0;
        else
            trig_prev_q <= trigger_in;
    end

    // selected edge of the trigger input
    always_comb
    begin
        case (ctrl.trigger_edge_ctrl_reg)
            tpt_pkg::EDGE_RISE: ext_edge = trigger_in && !trig_prev_q;
            tpt_pkg::EDGE_FALL: ext_edge = !trigger_in && trig_prev_q;
            tpt_pkg::EDGE_BOTH: ext_edge = trigger_in != trig_prev_q;
            default: ext_edge = 1'b0;
        endcase
    end

    assign trig = active && (ext_edge || soft_trigger_bit);

    ////////////////////////////////////////////////////////////////////////
    // compare selection: shadows in pwm, live registers in one-shot
    assign per_cmp = mode_os ? per_reg_q : per_sh_q;
    assign wid_cmp = mode_os ? wid_reg_q : wid_sh_q;
    // matches count only while a mode is live, so a disable raises no interrupt
    assign per_hit = running && active && (cnt_q == per_cmp);
    assign wid_hit = running && active && (cnt_q == wid_cmp);

    ////////////////////////////////////////////////////////////////////////
    // counter and run state next values
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        restart = 1'b0;
        if (!active)
        begin
            state_d = tpt_pkg::TPT_IDLE;
            cnt_d = tpt_pkg::CNT_IDLE;
        end
        else if (mode_pwm)
        begin
            if (trig)
            begin
                state_d = tpt_pkg::TPT_RUN;
                cnt_d = tpt_pkg::CNT_ZERO;
                restart = 1'b1;
            end
            else if (per_hit)
            begin
                cnt_d = tpt_pkg::CNT_ZERO;
                restart = 1'b1;
            end
            else if (running)
                cnt_d = cnt_q + tpt_pkg::CNT_ONE;
        end
        else if (!running)
        begin
            if (trig)
            begin
                state_d = tpt_pkg::TPT_RUN;
                cnt_d = tpt_pkg::CNT_ZERO;
            end
        end
        else if (per_hit)
        begin
            state_d = tpt_pkg::TPT_IDLE;
            cnt_d = tpt_pkg::CNT_IDLE;
        end
        else
            cnt_d = cnt_q + tpt_pkg::CNT_ONE;
    end

    // counter and run state
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= tpt_pkg::TPT_IDLE;
            cnt_q <= tpt_pkg::CNT_IDLE;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // compare registers as written by software
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            per_reg_q <= tpt_pkg::CMP_RESET;
            wid_reg_q <= tpt_pkg::CMP_RESET;
        end
        else
        begin
            if (wr.period_wr)
                per_reg_q <= wr.data;
            if (wr.width_wr)
                wid_reg_q <= wr.data;
        end
    end

    // shadow transfer armed by a width write, done at counter clear
    assign load = restart && (pend_q || !running);
    assign wid_next = load ? wid_reg_q : wid_sh_q;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            per_sh_q <= tpt_pkg::CMP_RESET;
            wid_sh_q <= tpt_pkg::CMP_RESET;
            pend_q <= 1'b0;
        end
        else
        begin
            if (load)
            begin
                per_sh_q <= per_reg_q;
                wid_sh_q <= wid_reg_q;
            end
            // a write in the transfer cycle keeps the request armed
            if (wr.width_wr)
                pend_q <= 1'b1;
            else if (load)
                pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse and aux output next values
    always_comb
    begin
        pulse_d = 1'b0;
        aux_d = 1'b0;
        if (mode_pwm)
        begin
            // high from clear until count reaches width
            pulse_d = (state_d == tpt_pkg::TPT_RUN) && (cnt_d < wid_next);
            aux_d = (trig || per_hit) ? !aux_q : aux_q;
        end
        else if (mode_os)
        begin
            aux_d = (state_d == tpt_pkg::TPT_RUN);
            if (state_d == tpt_pkg::TPT_IDLE)
                pulse_d = 1'b0;
            else if (cnt_d == wid_reg_q)
                pulse_d = 1'b1;
            else
                pulse_d = pulse_q;
        end
    end

    // outputs and period interrupt, one count after the match
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pulse_q <= 1'b0;
            aux_q <= 1'b0;
            per_irq_q <= 1'b0;
        end
        else
        begin
            pulse_q <= pulse_d;
            aux_q <= aux_d;
            per_irq_q <= per_hit && !(mode_pwm && trig);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output drive
    assign width_match_irq = wid_hit && !(mode_pwm && trig);
    assign period_match_irq = per_irq_q;
    assign pulse_out = pulse_q;
    assign aux_toggle_out = aux_q;
    assign status.count_readback_reg = cnt_q;
    assign status.period_compare_reg = per_reg_q;
    assign status.width_compare_reg = wid_reg_q;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    pwm_trig_clear_a: assert property (mode_pwm && trig |=> running && cnt_q == 16'h0000)
        else $error("pwm trigger did not clear counter");
    per_irq_clear_a: assert property (period_match_irq && $past(mode_pwm) && mode_pwm
        |-> cnt_q == 16'h0000)
        else $error("pwm period interrupt not at counter clear");
    pwm_wrap_a: assert property (mode_pwm && per_hit && !trig
        |=> cnt_q == 16'h0000
        ##1 (cnt_q == 16'h0001 || $past(!mode_pwm || trig || per_hit)))
        else $error("pwm counter did not wrap after period");
    shadow_hold_a: assert property (mode_pwm && running && !pend_q
        |=> per_sh_q == $past(per_sh_q) && wid_sh_q == $past(wid_sh_q))
        else $error("shadow changed without width write");
    zero_width_a: assert property (mode_pwm && $past(mode_pwm) && wid_sh_q == 16'h0000
        |-> !pulse_out)
        else $error("zero width gave output");
    width_edge_a: assert property (mode_pwm && width_match_irq |-> !pulse_out)
        else $error("width interrupt not aligned to output fall");
    os_ignore_a: assert property (mode_os && running && trig && !per_hit
        |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("one-shot trigger restarted counter");
    os_stop_a: assert property (mode_os && per_hit
        |=> !running && cnt_q == 16'hffff && period_match_irq && !pulse_out)
        else $error("one-shot did not stop after period match");
    os_aux_a: assert property (mode_os && $past(mode_os) |-> aux_toggle_out == running)
        else $error("one-shot aux output wrong");
    os_rise_a: assert property (mode_os && running && cnt_q != per_reg_q
        && cnt_q + 16'h0001 == wid_reg_q ##1 mode_os |-> pulse_out)
        else $error("one-shot output not raised at width");
    disable_a: assert property (!ctrl.counter_enable_bit
        |=> cnt_q == 16'hffff && !pulse_out && !aux_toggle_out)
        else $error("disable did not idle the timer");

    pwm_restart_c: cover property (mode_pwm && running && trig && !per_hit);
    os_pulse_c: cover property (mode_os && per_hit ##1 period_match_irq);
    width_irq_c: cover property (mode_pwm && width_match_irq);
    shadow_load_c: cover property (load && pend_q);

endmodule : tpt_triggered_pulse_timer

// file: verif/tpt_trigger_partner.sv
`timescale 1ns/1ps
// external trigger source and pulse load
module tpt_trigger_partner (
    input wire logic clk_sys,
    input wire logic fire,
    input wire logic [1:0] hold,
    input wire logic pulse_out,
    output logic trigger_in,
    output int hi_len,
    output int per_len
);
    int left = 0;
    int hc = 0;
    int pc = 0;
    logic last = 1'b0;

    initial
    begin
        trigger_in = 1'b0;
        hi_len = 0;
        per_len = 0;
    end

    ////////////////////////////////////////////////////////////
    // trigger level held hold+1 cycles, slow sources hold longer
    always @(posedge clk_sys)
    begin
        if (left == 0 && fire)
        begin
            trigger_in <= 1'b1;
            left <= int'(hold);
        end
        else if (left != 0)
            left <= left - 1;
        else
            trigger_in <= 1'b0;
    end

    // load side: active width and rise-to-rise distance
    always @(posedge clk_sys)
    begin
        last <= pulse_out;
        hc <= pulse_out ? hc + 1 : 0;
        if (!pulse_out && last)
            hi_len <= hc;
        pc <= (pulse_out && !last) ? 1 : pc + 1;
        if (pulse_out && !last)
            per_len <= pc;
    end
endmodule : tpt_trigger_partner

// file: verif/testbench.sv
`timescale 1ns/1ps
// self-checking bench with a cycle model of the timer
module testbench;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    tpt_pkg::tpt_ctrl_s ctrl = '0;
    tpt_pkg::tpt_ctrl_s c_last = '0;
    tpt_pkg::tpt_wr_s wr = '0;
    tpt_pkg::tpt_status_s status;
    logic soft_trigger_bit = 1'b0;
    logic fire = 1'b0;
    logic [1:0] hold = 2'h0;
    logic trigger_in, period_match_irq, width_match_irq, pulse_out, aux_toggle_out;
    int hi_len, per_len, p, w;
    int errors = 0;
    int checked = 0;
    logic [15:0] m_cnt, m_prd, m_wid, s_prd, s_wid;
    logic m_run, m_pul, m_aux, m_pirq, m_arm, m_prev, act, pwm;

    assign pwm = ctrl.mode_select_field == tpt_pkg::MODE_TRIG_PWM;
    assign act = ctrl.counter_enable_bit
        && (pwm || ctrl.mode_select_field == tpt_pkg::MODE_ONE_SHOT);

    initial
        forever #20 clk_sys = ~clk_sys;

    tpt_triggered_pulse_timer i_tpt_triggered_pulse_timer (
        .clk_sys(clk_sys), .reset_n(reset_n), .ctrl(ctrl),
        .soft_trigger_bit(soft_trigger_bit), .trigger_in(trigger_in), .wr(wr),
        .period_match_irq(period_match_irq), .width_match_irq(width_match_irq),
        .pulse_out(pulse_out), .aux_toggle_out(aux_toggle_out), .status(status));
    tpt_trigger_partner i_tpt_trigger_partner (
        .clk_sys(clk_sys), .fire(fire), .hold(hold), .pulse_out(pulse_out),
        .trigger_in(trigger_in), .hi_len(hi_len), .per_len(per_len));

    ////////////////////////////////////////////////////////////
    // reference model
    function automatic logic trig();
        return act && (soft_trigger_bit
            || (ctrl.trigger_edge_ctrl_reg[0] && trigger_in && !m_prev)
            || (ctrl.trigger_edge_ctrl_reg[1] && !trigger_in && m_prev));
    endfunction : trig

    always @(posedge clk_sys or negedge reset_n)
    begin : model
        logic t, pm;
        if (!reset_n)
        begin
            {m_cnt, m_run, m_pul, m_aux, m_pirq, m_arm, m_prev} = {16'hffff, 6'h00};
            {m_prd, m_wid, s_prd, s_wid} = 64'h0;
        end
        else
        begin
            t = trig();
            pm = m_run && m_cnt == (pwm ? s_prd : m_prd);
            m_pirq = 1'b0;
            if (!act)
                {m_cnt, m_run, m_pul, m_aux} = {16'hffff, 3'h0};
            else if (pwm)
            begin
                if (t || pm)
                begin
                    if (m_arm || !m_run)
                        {s_prd, s_wid, m_arm} = {m_prd, m_wid, 1'b0};
                    {m_pirq, m_aux, m_cnt, m_run} = {pm && !t, !m_aux, 16'h0000, 1'b1};
                end
                else if (m_run)
                    m_cnt = m_cnt + 16'h0001;
                m_pul = m_run && m_cnt < s_wid;
            end
            else if (m_run)
            begin
                if (pm)
                    {m_cnt, m_run, m_pul, m_aux, m_pirq} = {16'hffff, 4'h1};
                else
                    m_cnt = m_cnt + 16'h0001;
                m_pul = m_pul || (m_run && m_cnt == m_wid);
            end
            else if (t)
                {m_cnt, m_run, m_aux, m_pul} = {16'h0000, 2'h3, m_wid == 16'h0000};
            if (wr.width_wr)
                {m_wid, m_arm} = {wr.data, 1'b1};
            if (wr.period_wr)
                m_prd = wr.data;
            m_prev = trigger_in;
        end
    end

    // compare every output with the model between edges, the width interrupt only while ctrl is unchanged
    always @(negedge clk_sys)
    begin
        chk16(status.count_readback_reg, m_cnt);
        chk16(status.period_compare_reg, m_prd);
        chk16(status.width_compare_reg, m_wid);
        chk1(pulse_out, m_pul);
        chk1(aux_toggle_out, m_aux);
        chk1(period_match_irq, m_pirq);
        if (ctrl == c_last)
            chk1(width_match_irq, act && m_run && !(pwm && trig())
                && m_cnt == (pwm ? s_wid : m_wid));
        c_last = ctrl;
    end

    ////////////////////////////////////////////////////////////
    // drivers and checks
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask : chk1

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic setc(input logic en, input logic [2:0] md, input logic [1:0] ed);
        @(posedge clk_sys);
        ctrl <= '{en, md, ed};
    endtask : setc

    task automatic wreg(input logic wid, input int d);
        @(posedge clk_sys);
        wr <= '{!wid, wid, d[15:0]};
        @(posedge clk_sys);
        wr <= '0;
    endtask : wreg

    task automatic kick(input logic sw);
        @(posedge clk_sys);
        {soft_trigger_bit, fire} <= {sw, !sw};
        @(posedge clk_sys);
        {soft_trigger_bit, fire} <= 2'h0;
    endtask : kick

    task automatic rnd(input int n, input int pct);
        repeat (n)
        begin
            @(posedge clk_sys);
            soft_trigger_bit <= ($urandom % 100) < pct;
            fire <= ($urandom % 100) < pct;
            hold <= 2'($urandom);
        end
        @(posedge clk_sys);
        {soft_trigger_bit, fire, hold} <= 4'h0;
    endtask : rnd

    task automatic wait_pirq();
        int k;
        k = 0;
        // look only between edges, never in the launching time step
        @(negedge clk_sys);
        while (period_match_irq !== 1'b1 && k < 70000)
        begin
            @(negedge clk_sys);
            k++;
        end
        if (k >= 70000)
            errors++;
    endtask : wait_pirq

    task automatic final_report();
        if (errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    // watchdog, longest test is the wrap of about 65600 cycles
    initial
    begin
        tick(90000);
        errors++;
        final_report();
    end

    ////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        void'($urandom(81555));
        tick(8);
        reset_n <= 1'b1;
        p = 4 + $urandom % 12;
        w = 1 + $urandom % p;
        wreg(0, p);
        wreg(1, w);
        setc(1, tpt_pkg::MODE_TRIG_PWM, tpt_pkg::EDGE_RISE);
        kick(0);
        tick(3 * p + 9);
        chk16(hi_len[15:0], w[15:0]);
        chk16(per_len[15:0], 16'(p + 1));
        wait_pirq();
        wreg(0, p + 2);
        tick(2 * p + 12);
        wait_pirq();
        wreg(0, p + 3);
        wreg(1, w);
        for (int i = 0; i < 3; i++)
        begin
            wait_pirq();
            wreg(1, i == 0 ? 0 : (i == 1 ? p + 4 : $urandom % (p + 4)));
            tick(2 * p + 12);
        end
        setc(1, tpt_pkg::MODE_TRIG_PWM, tpt_pkg::EDGE_BOTH);
        rnd(600, 10);
        for (int m = 0; m < 8; m++)
        begin
            setc(0, 3'(m), 2'(m + 2));
            setc(1, 3'(m), 2'(m + 2));
            rnd(150, 6);
        end
        setc(0, tpt_pkg::MODE_ONE_SHOT, tpt_pkg::EDGE_FALL);
        wreg(0, 40);
        wreg(1, 30);
        setc(1, tpt_pkg::MODE_ONE_SHOT, tpt_pkg::EDGE_FALL);
        kick(1);
        tick(20);
        kick(0);
        tick(30);
        chk16(hi_len[15:0], 16'h000b);
        kick(1);
        tick(20);
        wreg(1, 10);
        wreg(0, 20);
        wait_pirq();
        tick(3);
        kick(1);
        tick(15);
        setc(0, tpt_pkg::MODE_ONE_SHOT, tpt_pkg::EDGE_FALL);
        tick(4);
        final_report();
    end
endmodule : testbench
